// ---- swt_defs.vh ----
// Constants for the sleep wake-up timer and low duty cycle listen block
`ifndef SWT_DEFS_VH
`define SWT_DEFS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SWT_ADDR_EXP_FINE   7'h14
`define SWT_ADDR_MANT_HIGH  7'h15
`define SWT_ADDR_MANT_LOW   7'h16
`define SWT_ADDR_CNT_HIGH   7'h17
`define SWT_ADDR_CNT_LOW    7'h18

// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define SWT_RST_EXP_FINE    8'h00
`define SWT_RST_MANT        8'h00
`define SWT_RST_BYTE        8'h00
`define SWT_EXP_MSB         5
`define SWT_EXP_LSB         2
`define SWT_FINE_MSB        1
`define SWT_FINE_LSB        0
`define SWT_EXP_FINE_MASK   8'h3F

// ---------------------------------------------------------------
// Timing constants, in slow oscillator ticks
// ---------------------------------------------------------------
// Wake period base factor is 32 ticks, i.e. a shift of 5
`define SWT_BASE_SHIFT      5'h05
// Extension unit is 2 x 32 ticks per (exponent - fine divider)
`define SWT_LDC_UNIT_SHIFT  6
// Receive window opened per wake period before giving up
`define SWT_LISTEN_TICKS    6'h20

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define SWT_PRE_W           21
`define SWT_UNIT_W          11

// ---------------------------------------------------------------
// Chip states
// ---------------------------------------------------------------
`define SWT_ST_AWAKE        2'h0
`define SWT_ST_SLEEP        2'h1
`define SWT_ST_LISTEN       2'h2
`define SWT_ST_EXTEND       2'h3

`endif

// ---- swt_tick_div.v ----
// Slow-tick divider: pulses once every (limit + 1) ticks
module swt_tick_div #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Control
  input  wire         clr,
  input  wire         tick,
  input  wire [W-1:0] limit,
  // Result
  output wire         wrap
);

  reg [W-1:0] cnt_reg;
  reg [W-1:0] cnt_next;

  assign wrap = tick && !clr && (cnt_reg == limit);

  always @* begin
    cnt_next = cnt_reg;
    if (clr || wrap)
      cnt_next = {W{1'b0}};
    else if (tick)
      cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      cnt_reg <= {W{1'b0}};
    else
      cnt_reg <= cnt_next;
  end

endmodule // swt_tick_div

// ---- swt_wake_timer.v ----
// Sleep wake-up timer with low duty cycle receive control
`include "swt_defs.vh"

module swt_wake_timer (
  // Clock and reset
  input  wire       CLK,
  input  wire       SYS_RST,
  // Register port
  input  wire [6:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_WE,
  input  wire       REG_RE,
  output wire [7:0] REG_RDATA,
  // Slow oscillator ticks, one clock wide
  input  wire       RC_TICK,
  input  wire       XTAL32_TICK,
  // Mode control
  input  wire       SLEEP_CMD,
  input  wire       WAKE_CMD,
  input  wire       WT_RUN_EN,
  input  wire       WT_IRQ_EN,
  input  wire       WT_PIN_SEL,
  input  wire       EXT_CRYSTAL_SELECT,
  input  wire       LDC_EN,
  input  wire [7:0] LDC_DUR,
  input  wire       STATUS_READ,
  // Receiver detect
  input  wire       PREAMBLE_OK,
  input  wire       SYNC_OK,
  // Outputs
  output wire       IRQ_N_PIN,
  output wire       WT_EVENT_FLAG,
  output wire       WT_PIN,
  output wire       CHIP_AWAKE,
  output wire       XTAL30_EN,
  output wire       RX_ON,
  output wire       SLOW_CLK_EXT,
  output wire       GENERAL_IO_PIN_ZERO_XTAL
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [7:0]  exp_fine_reg;
  reg  [7:0]  mant_high_reg;
  reg  [7:0]  mant_low_reg;
  reg  [7:0]  rdata_reg;

  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg         run_reg;
  reg         run_next;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [5:0]  listen_reg;
  reg  [5:0]  listen_next;
  reg         pre_seen_reg;
  reg         pre_seen_next;
  reg  [7:0]  units_reg;
  reg  [7:0]  units_next;
  reg         flag_reg;
  reg         flag_next;
  reg         irq_n_reg;
  reg         pin_reg;
  reg         awake_reg;
  reg         xtal30_reg;
  reg         rx_on_reg;
  reg         ext_sel_reg;

  wire [3:0]  exp_val;
  wire [1:0]  fine_val;
  wire [15:0] mant_val;
  wire [15:0] mant_last;
  wire [4:0]  pre_shift;
  wire [`SWT_PRE_W-1:0]  pre_limit;
  wire [3:0]  exp_minus_fine;
  wire [`SWT_UNIT_W-1:0] unit_limit;
  wire        tick;
  wire        pre_wrap;
  wire        unit_wrap;
  wire        expire;
  wire        detect;
  wire        in_rx;

  assign exp_val  = exp_fine_reg[`SWT_EXP_MSB:`SWT_EXP_LSB];
  assign fine_val = exp_fine_reg[`SWT_FINE_MSB:`SWT_FINE_LSB];
  assign mant_val = {mant_high_reg, mant_low_reg};

  // ---------------------------------------------------------------
  // Slow tick source
  // ---------------------------------------------------------------
  assign tick = ext_sel_reg ? XTAL32_TICK : RC_TICK;
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      ext_sel_reg <= 1'b0;
    else
      ext_sel_reg <= EXT_CRYSTAL_SELECT;
  end

  // ---------------------------------------------------------------
  // Period prescaler: 32 x 2^exp ticks, divided by 2^fine
  // ---------------------------------------------------------------
  // Fine divider takes resolution below the exponent step; a
  // fine value above exponent plus five clamps to one tick.
  assign pre_shift = (({1'b0, exp_val} + `SWT_BASE_SHIFT) > {3'h0, fine_val})
                   ? ({1'b0, exp_val} + `SWT_BASE_SHIFT - {3'h0, fine_val})
                   : 5'h00;
  assign pre_limit = ({{(`SWT_PRE_W-1){1'b0}}, 1'b1} << pre_shift)
                   - {{(`SWT_PRE_W-1){1'b0}}, 1'b1};

  swt_tick_div #(
    .W     (`SWT_PRE_W)
  ) u_pre (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clr   (!run_reg),
    .tick  (tick),
    .limit (pre_limit),
    .wrap  (pre_wrap)
  );

  // ---------------------------------------------------------------
  // Wake counter
  // ---------------------------------------------------------------
  // A zero mantissa behaves as one so the timer never stalls.
  assign mant_last = (mant_val == 16'h0000) ? 16'h0000
                   : (mant_val - 16'h0001);
  assign expire = run_reg && pre_wrap && (cnt_reg == mant_last);

  always @* begin
    cnt_next = cnt_reg;
    if (!run_reg || expire)
      cnt_next = 16'h0000;
    else if (pre_wrap)
      cnt_next = cnt_reg + 16'h0001;
  end

  // ---------------------------------------------------------------
  // Extension unit divider: 2 x 32 x (exp - fine) ticks
  // ---------------------------------------------------------------
  assign exp_minus_fine = (exp_val > {2'h0, fine_val})
                        ? (exp_val - {2'h0, fine_val}) : 4'h0;
  assign unit_limit = (exp_minus_fine == 4'h0) ? {`SWT_UNIT_W{1'b0}}
                    : (({7'h00, exp_minus_fine} << `SWT_LDC_UNIT_SHIFT)
                      - {{(`SWT_UNIT_W-1){1'b0}}, 1'b1});

  swt_tick_div #(
    .W     (`SWT_UNIT_W)
  ) u_unit (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clr   (state_reg != `SWT_ST_EXTEND),
    .tick  (tick),
    .limit (unit_limit),
    .wrap  (unit_wrap)
  );

  // ---------------------------------------------------------------
  // Chip state and listen control
  // ---------------------------------------------------------------
  assign detect = (pre_seen_reg || PREAMBLE_OK) && SYNC_OK;

  always @* begin
    state_next    = state_reg;
    run_next      = run_reg;
    listen_next   = listen_reg;
    pre_seen_next = pre_seen_reg;
    units_next    = units_reg;
    case (state_reg)
      `SWT_ST_AWAKE: begin
        run_next = 1'b0;
        if (SLEEP_CMD) begin
          state_next = `SWT_ST_SLEEP;
          run_next   = WT_RUN_EN;
        end
      end
      `SWT_ST_SLEEP: begin
        if (expire && WT_IRQ_EN) begin
          state_next = `SWT_ST_AWAKE;
          run_next   = 1'b0;
        end else if (expire && LDC_EN) begin
          state_next    = `SWT_ST_LISTEN;
          listen_next   = 6'h00;
          pre_seen_next = 1'b0;
        end
      end
      `SWT_ST_LISTEN: begin
        if (PREAMBLE_OK)
          pre_seen_next = 1'b1;
        if (detect) begin
          state_next = `SWT_ST_EXTEND;
          units_next = 8'h00;
        end else if (tick) begin
          if (listen_reg == `SWT_LISTEN_TICKS - 6'h01)
            state_next = `SWT_ST_SLEEP;
          else
            listen_next = listen_reg + 6'h01;
        end
      end
      `SWT_ST_EXTEND: begin
        if (units_reg >= LDC_DUR)
          state_next = `SWT_ST_SLEEP;
        else if (unit_wrap)
          units_next = units_reg + 8'h01;
      end
      default: begin
        state_next = `SWT_ST_AWAKE;
        run_next   = 1'b0;
      end
    endcase
    // An interrupt-enabled expiry during a listen window still wakes
    if (expire && WT_IRQ_EN && (state_reg != `SWT_ST_SLEEP)
        && (state_reg != `SWT_ST_AWAKE)) begin
      state_next = `SWT_ST_AWAKE;
      run_next   = 1'b0;
    end
    if (WAKE_CMD) begin
      state_next = `SWT_ST_AWAKE;
      run_next   = 1'b0;
    end
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg    <= `SWT_ST_AWAKE;
      run_reg      <= 1'b0;
      cnt_reg      <= 16'h0000;
      listen_reg   <= 6'h00;
      pre_seen_reg <= 1'b0;
      units_reg    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      run_reg      <= run_next;
      cnt_reg      <= cnt_next;
      listen_reg   <= listen_next;
      pre_seen_reg <= pre_seen_next;
      units_reg    <= units_next;
    end
  end

  // ---------------------------------------------------------------
  // Event flag, interrupt and pin function
  // ---------------------------------------------------------------
  // Set wins over the status-read clear in the same cycle.
  always @* begin
    flag_next = flag_reg;
    if (STATUS_READ)
      flag_next = 1'b0;
    if (expire && WT_IRQ_EN)
      flag_next = 1'b1;
  end

  assign in_rx = (state_next == `SWT_ST_LISTEN)
              || (state_next == `SWT_ST_EXTEND);

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flag_reg   <= 1'b0;
      irq_n_reg  <= 1'b1;
      pin_reg    <= 1'b0;
      awake_reg  <= 1'b1;
      xtal30_reg <= 1'b1;
      rx_on_reg  <= 1'b0;
    end else begin
      flag_reg   <= flag_next;
      irq_n_reg  <= !flag_next;
      pin_reg    <= expire && WT_PIN_SEL;
      awake_reg  <= (state_next == `SWT_ST_AWAKE);
      xtal30_reg <= (state_next == `SWT_ST_AWAKE);
      rx_on_reg  <= in_rx;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      exp_fine_reg  <= `SWT_RST_EXP_FINE;
      mant_high_reg <= `SWT_RST_MANT;
      mant_low_reg  <= `SWT_RST_MANT;
    end else if (REG_WE) begin
      case (REG_ADDR)
        `SWT_ADDR_EXP_FINE:  exp_fine_reg  <= REG_WDATA & `SWT_EXP_FINE_MASK;
        `SWT_ADDR_MANT_HIGH: mant_high_reg <= REG_WDATA;
        `SWT_ADDR_MANT_LOW:  mant_low_reg  <= REG_WDATA;
        default: ;
      endcase
    end
  end

  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      rdata_reg <= `SWT_RST_BYTE;
    else if (REG_RE) begin
      case (REG_ADDR)
        `SWT_ADDR_EXP_FINE:  rdata_reg <= exp_fine_reg;
        `SWT_ADDR_MANT_HIGH: rdata_reg <= mant_high_reg;
        `SWT_ADDR_MANT_LOW:  rdata_reg <= mant_low_reg;
        `SWT_ADDR_CNT_HIGH:  rdata_reg <= cnt_reg[15:8];
        `SWT_ADDR_CNT_LOW:   rdata_reg <= cnt_reg[7:0];
        default:             rdata_reg <= `SWT_RST_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  assign REG_RDATA                = rdata_reg;
  assign IRQ_N_PIN                = irq_n_reg;
  assign WT_EVENT_FLAG            = flag_reg;
  assign WT_PIN                   = pin_reg;
  assign CHIP_AWAKE               = awake_reg;
  assign XTAL30_EN                = xtal30_reg;
  assign RX_ON                    = rx_on_reg;
  assign SLOW_CLK_EXT             = ext_sel_reg;
  assign GENERAL_IO_PIN_ZERO_XTAL = ext_sel_reg;

endmodule // swt_wake_timer

// ---- swt_host.sv ----
// Host model that answers the wake interrupt by reading status
module swt_host #(
  parameter int DLY = 2
) (
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Device side
  input  logic irq_n,
  output logic status_read
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;

  // Status read a few cycles after the pin falls, retried if still low
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 4'h0;
      status_read <= 1'h0;
    end else begin
      status_read <= (wait_cnt == 4'(DLY));
      wait_cnt <= (!irq_n && wait_cnt <= 4'(DLY)) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // swt_host

// ---- swt_wake_timer_chk.sv ----
// Port checker for the wake timer block
module swt_wake_timer_chk (
  // Clock and reset
  input logic CLK,
  input logic SYS_RST,
  // Inputs
  input logic RC_TICK,
  input logic XTAL32_TICK,
  input logic SLEEP_CMD,
  input logic WAKE_CMD,
  input logic WT_IRQ_EN,
  input logic WT_PIN_SEL,
  input logic EXT_CRYSTAL_SELECT,
  input logic LDC_EN,
  input logic STATUS_READ,
  // Outputs
  input logic IRQ_N_PIN,
  input logic WT_EVENT_FLAG,
  input logic WT_PIN,
  input logic CHIP_AWAKE,
  input logic XTAL30_EN,
  input logic RX_ON,
  input logic SLOW_CLK_EXT,
  input logic GENERAL_IO_PIN_ZERO_XTAL
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_irq_en;
    $fell(IRQ_N_PIN) |-> $past(WT_IRQ_EN) && WT_EVENT_FLAG;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt without enable");
  property p_irq_hold;
    !IRQ_N_PIN && !STATUS_READ |=> !IRQ_N_PIN;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt released early");
  property p_wake;
    $fell(IRQ_N_PIN) |-> CHIP_AWAKE && XTAL30_EN;
  endproperty
  a_wake: assert property (p_wake)
    else $error("interrupt without wake");
  property p_sleep;
    CHIP_AWAKE && SLEEP_CMD && !WAKE_CMD |=> !CHIP_AWAKE && !XTAL30_EN;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep command not taken");
  property p_stay;
    !CHIP_AWAKE && !WT_IRQ_EN && !WAKE_CMD |=> !CHIP_AWAKE;
  endproperty
  a_stay: assert property (p_stay)
    else $error("woke without command");
  property p_wake_cmd;
    WAKE_CMD |=> CHIP_AWAKE;
  endproperty
  a_wake_cmd: assert property (p_wake_cmd)
    else $error("wake command ignored");
  property p_pin;
    $rose(WT_PIN) |-> $past(WT_PIN_SEL) && $past(RC_TICK || XTAL32_TICK)
      ##1 !WT_PIN;
  endproperty
  a_pin: assert property (p_pin)
    else $error("bad pin pulse");
  property p_xtal;
    EXT_CRYSTAL_SELECT |=> SLOW_CLK_EXT && GENERAL_IO_PIN_ZERO_XTAL;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal select not applied");
  property p_listen;
    $rose(RX_ON) |-> !CHIP_AWAKE && $past(LDC_EN);
  endproperty
  a_listen: assert property (p_listen)
    else $error("receiver on outside listen");
  c_irq: cover property ($fell(IRQ_N_PIN));
  c_rx: cover property ($rose(RX_ON));
  c_pin: cover property ($rose(WT_PIN));
endmodule // swt_wake_timer_chk

// ---- swt_tb.sv ----
// Testbench for the wake timer block
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] dur = 8'h00;
  logic [7:0] rdata, d, e;
  logic [2:0] ph = 3'h0;
  logic       we = 0, re = 0, rc = 0, xt = 0, sc = 0, wk = 0, run = 1;
  logic       ien = 0, psel = 0, ext = 0, ldc = 0, pre = 0, syn = 0;
  logic       clr = 0, sread, irq_n, flag, wpin, awake, x30, rx_on;
  logic       sext, g0x;
  int         tk = 0, pins = 0, rxt = 0, fails = 0, compares = 0, i;

  always #12.5 clk = ~clk;
  // Slow ticks: internal every 4 cycles, crystal every 8
  always @(negedge clk) begin
    ph <= ph + 3'h1;
    rc <= (ph[1:0] == 2'h3);
    xt <= (ph == 3'h5);
  end
  always @(posedge clk) begin
    tk <= clr ? 0 : tk + int'(ext ? xt : rc);
    pins <= clr ? 0 : pins + int'(wpin);
    rxt <= clr ? 0 : rxt + int'(rx_on & (ext ? xt : rc));
  end

  swt_wake_timer i_dut (
    .CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .RC_TICK(rc),
    .XTAL32_TICK(xt), .SLEEP_CMD(sc), .WAKE_CMD(wk), .WT_RUN_EN(run),
    .WT_IRQ_EN(ien), .WT_PIN_SEL(psel), .EXT_CRYSTAL_SELECT(ext),
    .LDC_EN(ldc), .LDC_DUR(dur), .STATUS_READ(sread),
    .PREAMBLE_OK(pre), .SYNC_OK(syn), .IRQ_N_PIN(irq_n),
    .WT_EVENT_FLAG(flag), .WT_PIN(wpin), .CHIP_AWAKE(awake),
    .XTAL30_EN(x30), .RX_ON(rx_on), .SLOW_CLK_EXT(sext),
    .GENERAL_IO_PIN_ZERO_XTAL(g0x)
  );
  swt_host i_host (.clk(clk), .rst(rst), .irq_n(irq_n), .status_read(sread));

  task wr(input [6:0] a, input [7:0] v);
    @(negedge clk) {addr, wdata, we} = {a, v, 1'h1};
    @(negedge clk) we = 1'h0;
  endtask
  task rd(input [6:0] a, output [7:0] v);
    @(negedge clk) {addr, re} = {a, 1'h1};
    @(negedge clk) re = 1'h0;
    v = rdata;
  endtask
  task prog(input [7:0] x, input [15:0] m);
    wr(7'h14, x);
    wr(7'h15, m[15:8]);
    wr(7'h16, m[7:0]);
  endtask
  task pulse(input bit slp);
    @(negedge clk) {sc, wk, clr} = {slp, !slp, 1'h1};
    @(negedge clk) {sc, wk, clr} = 3'h0;
  endtask
  task go(input int t);
    for (i = 0; i < 20000 && tk < t; i++) @(negedge clk);
  endtask
  task irq_run(input [7:0] x, input [15:0] m, input int n);
    prog(x, m);
    pulse(1);
    for (i = 0; i < 8000 && irq_n; i++) @(negedge clk);
    `CHK(irq_n, 1'h0)
    `CHK(flag, 1'h1)
    `CHK(tk, n)
    `CHK(({awake, x30}), 2'h3)
    repeat (8) @(negedge clk);
    `CHK(irq_n, 1'h1)
  endtask
  task wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    for (int k = 0; k < 3; k++) begin
      rd(7'h14 + 7'(k), d);
      `CHK(d, 8'h00)
    end
    wr(7'h14, 8'hFF);
    rd(7'h14, d);
    `CHK(d, 8'h3F)
    wr(7'h17, 8'h55);
    rd(7'h17, d);
    `CHK(d, 8'h00)
    rd(7'h30, d);
    `CHK(d, 8'h00)
    run = 1'h0;
    prog(8'h00, 16'h0001);
    pulse(1);
    go(40);
    rd(7'h18, d);
    `CHK(d, 8'h00)
    `CHK(({awake, irq_n}), 2'h1)
    pulse(0);
    run = 1'h1;
    $display("test 1 done");
    ien = 1'h1;
    psel = 1'h1;
    irq_run(8'h00, 16'h0001, 32);
    irq_run(8'h04, 16'h0002, 128);
    irq_run(8'h09, 16'h0003, 192);
    $display("test 2 done");
    ien = 1'h0;
    prog(8'h03, 16'h0104);
    pulse(1);
    go(1030);
    rd(7'h17, d);
    rd(7'h18, e);
    `CHK(d, 8'h01)
    `CHK(e, 8'h01)
    go(2090);
    `CHK(pins, 2)
    `CHK(({awake, irq_n}), 2'h1)
    pulse(0);
    `CHK(awake, 1'h1)
    $display("test 3 done");
    psel = 1'h0;
    ldc = 1'h1;
    prog(8'h00, 16'h0002);
    pulse(1);
    go(190);
    `CHK(rxt, 64)
    `CHK(awake, 1'h0)
    pulse(0);
    {pre, syn, dur} = {2'h3, 8'h02};
    prog(8'h04, 16'h0004);
    pulse(1);
    go(450);
    `CHK(rxt, 128)
    pulse(0);
    {pre, syn, ldc} = 3'h0;
    $display("test 4 done");
    {ext, ien} = 2'h3;
    repeat (2) @(negedge clk);
    `CHK(({sext, g0x}), 2'h3)
    irq_run(8'h00, 16'h0001, 32);
    $display("test 5 done");
    wrap_up;
  end
  initial begin
    #1000000;
    fails++;
    wrap_up;
  end
endmodule // tb

bind swt_wake_timer swt_wake_timer_chk i_chk (
  .CLK, .SYS_RST, .RC_TICK, .XTAL32_TICK, .SLEEP_CMD, .WAKE_CMD,
  .WT_IRQ_EN, .WT_PIN_SEL, .EXT_CRYSTAL_SELECT, .LDC_EN, .STATUS_READ,
  .IRQ_N_PIN, .WT_EVENT_FLAG, .WT_PIN, .CHIP_AWAKE, .XTAL30_EN, .RX_ON,
  .SLOW_CLK_EXT, .GENERAL_IO_PIN_ZERO_XTAL
);
